// [rtl/tdc_timer_ctrl.sv]
// dual timer/counter with external interrupt flags behind an APB slave
// Behaviour
// - timer1 overflow sets control bit 7; ISR entry clears; software may write
// - timer0 overflow sets control bit 5; ISR entry clears; software may write
// - control bit 6 runs timer1 when 1, halts it when 0
// - control bit 4 runs timer0 when 1, halts it when 0
// - ext request flags bits 3,1: edge mode cleared at ISR entry, level follows pin
// - type bits 2 and 0 choose falling-edge or low-level flag trigger; only edge mode sets interrupt status
// - mode bit 7 set: timer1 counts only while ext pin 1 high and run set
// - mode bit 3 set: timer0 counts only while ext pin 0 high and run set
// - mode bit 6: timer1 counts internal clock when clear, pin falling edges when set
// - mode bit 2: timer0 counts internal clock when clear, pin falling edges when set
// - mode bits 5:4 select timer1 mode, bits 1:0 timer0 mode
// - mode 0: 8-bit high byte counter behind 5-bit low-byte prescaler
// - mode 1: full 16-bit counter, no prescaler
// - mode 2: 8-bit low counter reloaded from high byte on overflow
// - mode 3: timer0 split in two 8-bit halves, timer1 stopped
// - timer mode clock is system clock divided by 4 or by 12
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module tdc_timer_ctrl (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    // interrupt
    output logic irq
);
    // one step of a timer in modes 0 to 3; mode 3 handles the low byte only
    function automatic tdc_pkg::tdc_step_s tdc_step(input logic [7:0] low, input logic [7:0] high,
                                                    input logic [1:0] mode, input logic en);
        tdc_pkg::tdc_step_s s;
        s.ovf = 1'b0;
        s.high = high;
        s.low = low;
        if (en) begin
            case (mode)
                tdc_pkg::TDC_MODE_PRESCALE: begin
                    s.low = {low[7:5], 5'(low[4:0] + 5'h01)};
                    if (low[4:0] == tdc_pkg::TDC_PRESCALE_LAST) begin
                        s.high = 8'(high + 8'h01);
                        s.ovf = (high == tdc_pkg::TDC_BYTE_LAST);
                    end
                end
                tdc_pkg::TDC_MODE_WIDE: begin
                    {s.high, s.low} = 16'({high, low} + 16'h0001);
                    s.ovf = ({high, low} == {tdc_pkg::TDC_BYTE_LAST, tdc_pkg::TDC_BYTE_LAST});
                end
                tdc_pkg::TDC_MODE_RELOAD: begin
                    s.ovf = (low == tdc_pkg::TDC_BYTE_LAST);
                    s.low = s.ovf ? high : 8'(low + 8'h01);
                end
                default: begin
                    s.low = 8'(low + 8'h01);
                    s.ovf = (low == tdc_pkg::TDC_BYTE_LAST);
                end
            endcase
        end
        return s;
    endfunction

    // apb decode
    logic [7:0] idx;
    logic addr_ok;
    logic hit_tctrl, hit_tmode, hit_clksel, hit_status, hit_mask, hit_entry;
    logic [1:0] hit_low, hit_high;
    logic mapped;
    logic acc;
    logic wr_en;
    logic [31:0] rd_mux;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // control and configuration state
    logic [1:0] tf_q, tr_q, ie_q, it_q;
    tdc_pkg::tdc_tmode_s tmode_q;
    logic [1:0] clksel_q;
    logic [7:0] low_q [2];
    logic [7:0] high_q [2];
    logic [3:0] status_q, mask_q;
    logic irq_q;
    logic [3:0] div_q;

    // pin synchronisers: [0] ext0, [1] ext1, [2] count0, [3] count1
    logic [3:0] pin_raw, sync1_q, sync2_q, prev_q, fall;

    // time base
    logic tick_slow, tick_fast;

    // per-timer stepping
    logic [1:0] mode [2];
    logic [1:0] run_en;
    tdc_pkg::tdc_step_s step [2];
    tdc_pkg::tdc_step_s split_high;
    logic split;
    logic [1:0] ovf_ev;
    logic [1:0] ext_set;
    logic [1:0] entry_tf, entry_ie;
    logic [3:0] events;
    tdc_pkg::tdc_tctrl_s tctrl_rd;

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign hit_tctrl = addr_ok && (idx == tdc_pkg::TDC_IDX_TCTRL);
    assign hit_tmode = addr_ok && (idx == tdc_pkg::TDC_IDX_TMODE);
    assign hit_low[0] = addr_ok && (idx == tdc_pkg::TDC_IDX_LOW0);
    assign hit_low[1] = addr_ok && (idx == tdc_pkg::TDC_IDX_LOW1);
    assign hit_high[0] = addr_ok && (idx == tdc_pkg::TDC_IDX_HIGH0);
    assign hit_high[1] = addr_ok && (idx == tdc_pkg::TDC_IDX_HIGH1);
    assign hit_clksel = addr_ok && (idx == tdc_pkg::TDC_IDX_CLKSEL);
    assign hit_status = addr_ok && (idx == tdc_pkg::TDC_IDX_IRQ_STATUS);
    assign hit_mask = addr_ok && (idx == tdc_pkg::TDC_IDX_IRQ_MASK);
    assign hit_entry = addr_ok && (idx == tdc_pkg::TDC_IDX_ISR_ENTRY);
    assign mapped = hit_tctrl | hit_tmode | (|hit_low) | (|hit_high) | hit_clksel
                  | hit_status | hit_mask | hit_entry;
    // access completes one cycle after entering the access phase
    assign acc = psel && penable && !pready_q;
    assign wr_en = ce && psel && penable && pready_q && pwrite && !pslverr_q;

    assign tctrl_rd = '{timer1_overflow_flag: tf_q[1], timer1_run_bit: tr_q[1],
                        timer0_overflow_flag: tf_q[0], timer0_run_bit: tr_q[0],
                        ext_irq1_request_flag: ie_q[1], ext_irq1_type_bit: it_q[1],
                        ext_irq0_request_flag: ie_q[0], ext_irq0_type_bit: it_q[0]};

    assign rd_mux = hit_tctrl ? {24'h000000, tctrl_rd} :
                    hit_tmode ? {24'h000000, tmode_q} :
                    hit_low[0] ? {24'h000000, low_q[0]} :
                    hit_low[1] ? {24'h000000, low_q[1]} :
                    hit_high[0] ? {24'h000000, high_q[0]} :
                    hit_high[1] ? {24'h000000, high_q[1]} :
                    hit_clksel ? {24'h000000, 3'h0, clksel_q, 3'h0} :
                    hit_status ? {28'h0000000, status_q} :
                    hit_mask ? {28'h0000000, mask_q} : 32'h00000000;

    // isr entry strobes: software reports entry by writing ones
    assign entry_tf = (wr_en && hit_entry) ? pwdata[1:0] : 2'h0;
    assign entry_ie = (wr_en && hit_entry) ? pwdata[3:2] : 2'h0;

    // apb handshake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= acc;
            pslverr_q <= acc && !mapped;
            if (acc && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // time base: fast tick every 4th, slow every 12th clock
    assign tick_slow = (div_q == tdc_pkg::TDC_DIV_SLOW_LAST);
    assign tick_fast = (div_q[1:0] == tdc_pkg::TDC_DIV_FAST_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 4'h0;
        end else if (ce) begin
            div_q <= tick_slow ? 4'h0 : 4'(div_q + 4'h1);
        end
    end

    // pins cross into the clock domain before any logic reads them
    assign pin_raw = {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
    assign fall = prev_q & ~sync2_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
            prev_q <= 4'hF;
        end else if (ce) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign mode[0] = {tmode_q.tmr0.mode_field_high, tmode_q.tmr0.mode_field_low};
    assign mode[1] = {tmode_q.tmr1.mode_field_high, tmode_q.tmr1.mode_field_low};
    assign split = (mode[0] == tdc_pkg::TDC_MODE_SPLIT);

    // per-timer clock source, gating, run control and step
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_timer
            tdc_pkg::tdc_tcfg_s cfg;
            logic clk_src;
            logic tb_tick;
            assign cfg = (i == 0) ? tmode_q.tmr0 : tmode_q.tmr1;
            assign tb_tick = clksel_q[i] ? tick_fast : tick_slow;
            assign clk_src = cfg.counter_sel ? fall[2 + i] : tb_tick;
            // gate pin is the synchronised ext interrupt pin
            assign run_en[i] = tr_q[i] && (!cfg.gate || sync2_q[i]) && clk_src;
            // timer1 in its own mode 3 holds its count
            assign step[i] = tdc_step(low_q[i], high_q[i], mode[i],
                                      run_en[i] && !(i == 1 && mode[i] == tdc_pkg::TDC_MODE_SPLIT));
            // ext request set: falling edge or low level
            assign ext_set[i] = it_q[i] ? fall[i] : !sync2_q[i];
        end
    endgenerate

    // split high half of timer0 runs from timer1 run bit on the internal clock
    assign split_high = tdc_step(high_q[0], 8'h00, tdc_pkg::TDC_MODE_SPLIT,
                                 tr_q[1] && (clksel_q[1] ? tick_fast : tick_slow));

    // in split mode the high half of timer0 owns the timer1 flag
    assign ovf_ev[0] = ce && step[0].ovf;
    assign ovf_ev[1] = ce && (split ? split_high.ovf : step[1].ovf);

    assign events = {ce & ext_set[1] & it_q[1], ce & ext_set[0] & it_q[0], ovf_ev};

    // count bytes; a software write beats a count in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_q[0] <= tdc_pkg::TDC_RST_COUNT;
            low_q[1] <= tdc_pkg::TDC_RST_COUNT;
            high_q[0] <= tdc_pkg::TDC_RST_COUNT;
            high_q[1] <= tdc_pkg::TDC_RST_COUNT;
        end else if (ce) begin
            low_q[0] <= (wr_en && hit_low[0]) ? pwdata[7:0] : step[0].low;
            low_q[1] <= (wr_en && hit_low[1]) ? pwdata[7:0] : step[1].low;
            high_q[0] <= (wr_en && hit_high[0]) ? pwdata[7:0] : (split ? split_high.low : step[0].high);
            high_q[1] <= (wr_en && hit_high[1]) ? pwdata[7:0] : step[1].high;
        end
    end

    // control register: hardware set wins over software or entry clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {tf_q[1], tr_q[1], tf_q[0], tr_q[0], ie_q[1], it_q[1], ie_q[0], it_q[0]} <= tdc_pkg::TDC_RST_TCTRL;
        end else if (ce) begin
            if (wr_en && hit_tctrl) begin
                {tr_q[1], tr_q[0], it_q[1], it_q[0]} <= {pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
            end
            tf_q[1] <= ((wr_en && hit_tctrl) ? pwdata[7] : (tf_q[1] && !entry_tf[1])) || ovf_ev[1];
            tf_q[0] <= ((wr_en && hit_tctrl) ? pwdata[5] : (tf_q[0] && !entry_tf[0])) || ovf_ev[0];
            for (int k = 0; k < 2; k++) begin
                if (!it_q[k]) begin
                    ie_q[k] <= ext_set[k];
                end else begin
                    ie_q[k] <= ((wr_en && hit_tctrl) ? pwdata[1 + 2 * k] : (ie_q[k] && !entry_ie[k])) || ext_set[k];
                end
            end
        end
    end

    // mode, clock select, interrupt status and mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmode_q <= tdc_pkg::TDC_RST_TMODE;
            clksel_q <= tdc_pkg::TDC_RST_CLKSEL;
            status_q <= tdc_pkg::TDC_RST_IRQ;
            mask_q <= tdc_pkg::TDC_RST_IRQ;
            irq_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && hit_tmode) begin
                tmode_q <= pwdata[7:0];
            end
            if (wr_en && hit_clksel) begin
                clksel_q <= {pwdata[tdc_pkg::TDC_POS_TMR1_CLKSEL], pwdata[tdc_pkg::TDC_POS_TMR0_CLKSEL]};
            end
            if (wr_en && hit_mask) begin
                mask_q <= pwdata[3:0];
            end
            // new events survive a write-one-to-clear in the same cycle
            status_q <= (status_q & ~((wr_en && hit_status) ? pwdata[3:0] : 4'h0)) | events;
            // one cycle behind the status bits, from a flop
            irq_q <= |(status_q & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule

// [rtl/tdc_pkg.sv]
// package: register map, field positions and types for the dual timer block
package tdc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] TDC_IDX_TCTRL = 8'h88;
    localparam logic [7:0] TDC_IDX_TMODE = 8'h89;
    localparam logic [7:0] TDC_IDX_LOW0 = 8'h8A;
    localparam logic [7:0] TDC_IDX_LOW1 = 8'h8B;
    localparam logic [7:0] TDC_IDX_HIGH0 = 8'h8C;
    localparam logic [7:0] TDC_IDX_HIGH1 = 8'h8D;
    localparam logic [7:0] TDC_IDX_CLKSEL = 8'h8E;
    localparam logic [7:0] TDC_IDX_IRQ_STATUS = 8'hF0;
    localparam logic [7:0] TDC_IDX_IRQ_MASK = 8'hF1;
    localparam logic [7:0] TDC_IDX_ISR_ENTRY = 8'hF2;
    // reset values
    localparam logic [7:0] TDC_RST_TCTRL = 8'h00;
    localparam logic [7:0] TDC_RST_TMODE = 8'h00;
    localparam logic [7:0] TDC_RST_COUNT = 8'h00;
    localparam logic [1:0] TDC_RST_CLKSEL = 2'h0;
    localparam logic [3:0] TDC_RST_IRQ = 4'h0;
    // clock select byte positions
    localparam int TDC_POS_TMR0_CLKSEL = 3;
    localparam int TDC_POS_TMR1_CLKSEL = 4;
    // time base: machine clock dividers
    localparam logic [3:0] TDC_DIV_SLOW_LAST = 4'hB;
    localparam logic [1:0] TDC_DIV_FAST_LAST = 2'h3;
    // mode field values
    localparam logic [1:0] TDC_MODE_PRESCALE = 2'h0;
    localparam logic [1:0] TDC_MODE_WIDE = 2'h1;
    localparam logic [1:0] TDC_MODE_RELOAD = 2'h2;
    localparam logic [1:0] TDC_MODE_SPLIT = 2'h3;
    localparam logic [4:0] TDC_PRESCALE_LAST = 5'h1F;
    localparam logic [7:0] TDC_BYTE_LAST = 8'hFF;

    typedef struct packed {
        logic timer1_overflow_flag;
        logic timer1_run_bit;
        logic timer0_overflow_flag;
        logic timer0_run_bit;
        logic ext_irq1_request_flag;
        logic ext_irq1_type_bit;
        logic ext_irq0_request_flag;
        logic ext_irq0_type_bit;
    } tdc_tctrl_s;

    typedef struct packed {
        logic gate;
        logic counter_sel;
        logic mode_field_high;
        logic mode_field_low;
    } tdc_tcfg_s;

    typedef struct packed {
        tdc_tcfg_s tmr1;
        tdc_tcfg_s tmr0;
    } tdc_tmode_s;

    // one step of a timer: overflow, new high byte, new low byte
    typedef struct packed {
        logic ovf;
        logic [7:0] high;
        logic [7:0] low;
    } tdc_step_s;
endpackage

// [verification/tdc_monitor.sv]
// checker for the dual timer control block, apb side
`timescale 1ns/10ps
module tdc_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and interrupt
    input wire logic ext_irq0_pin,
    input wire logic irq
);
    logic [7:0] mode_q;
    logic [7:0] ctl_q;
    wire [7:0] idx = paddr[9:2];
    wire done_w = pready && !pslverr;
    wire rd_mode = done_w && !pwrite && idx == tdc_pkg::TDC_IDX_TMODE;
    wire rd_ctl = done_w && !pwrite && idx == tdc_pkg::TDC_IDX_TCTRL;
    // shadow whole written bytes; compare only software-owned bits, flags move under hardware
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            ctl_q <= 8'h00;
        end else if (done_w && pwrite) begin
            if (idx == tdc_pkg::TDC_IDX_TMODE) mode_q <= pwdata[7:0];
            if (idx == tdc_pkg::TDC_IDX_TCTRL) ctl_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_mode_readback: assert property (rd_mode |-> prdata[7:0] == mode_q)
        else $error("mode readback differs");
    a_run1_readback: assert property (rd_ctl |-> prdata[6] == ctl_q[6])
        else $error("timer1 run bit differs");
    a_run0_readback: assert property (rd_ctl |-> prdata[4] == ctl_q[4])
        else $error("timer0 run bit differs");
    a_type_readback: assert property (rd_ctl |-> prdata[2] == ctl_q[2] && prdata[0] == ctl_q[0])
        else $error("type bits differ");
    a_level_follow: assert property (ext_irq0_pin [*6] ##0 (rd_ctl && !ctl_q[0]) |-> !prdata[1])
        else $error("level flag set while pin high");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
        else $error("ready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    c_mode_read: cover property (rd_mode);
    c_refused: cover property (pslverr);
    c_irq_rise: cover property ($rose(irq));
endmodule

// [verification/tdc_pin_model.sv]
// far-side model of the interrupt and count pins
`timescale 1ns/10ps
module tdc_pin_model (
    // clock
    input wire logic clk,
    // pins, pulled up while idle
    output logic ext_irq0_pin,
    output logic ext_irq1_pin,
    output logic timer0_count_pin,
    output logic timer1_count_pin
);
    logic [3:0] pin_q = 4'hF;
    assign {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin} = pin_q;
    // equal low and high time so the sync chain sees both levels
    task automatic pulse(input int i, input int len);
        pin_q[i] <= 1'b0;
        repeat (len) @(posedge clk);
        pin_q[i] <= 1'b1;
        repeat (len) @(posedge clk);
    endtask
    task automatic hold(input int i, input logic lv);
        pin_q[i] <= lv;
        @(posedge clk);
    endtask
endmodule

// [verification/tb.sv]
// testbench for the dual timer control block
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, err;
    wire e0, e1, c0, c1;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h37191d3d;
    int k;
    logic [7:0] v, m, t;
    always #12.5 clk = ~clk;
    tdc_pin_model pins (.clk(clk), .ext_irq0_pin(e0), .ext_irq1_pin(e1), .timer0_count_pin(c0),
        .timer1_count_pin(c1));
    tdc_timer_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq0_pin(e0), .ext_irq1_pin(e1), .timer0_count_pin(c0), .timer1_count_pin(c1), .irq(irq));
    task automatic test_done;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chkr(input string s, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
        cmp_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_errors++;
            $display("wrong value %s exp %h..%h got %h", s, lo, hi, g);
        end
    endtask
    // ready taken at the rising edge; one idle edge after release so no strobe is set twice
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        v = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            test_done();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task automatic rd(input logic [7:0] i);
        apb(1'b0, i, 8'h00);
    endtask
    function automatic logic [7:0] ticks(input int c, input logic [7:0] f);
        return 8'(c / (f != 0 ? 4 : 12));
    endfunction
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(tdc_pkg::TDC_IDX_TMODE);
        chk("mode reset", tdc_pkg::TDC_RST_TMODE, v);
        m = 8'($random(seed));
        wr(tdc_pkg::TDC_IDX_TMODE, m);
        rd(tdc_pkg::TDC_IDX_TMODE);
        chk("mode", m, v);
        rd(8'h00);
        chk("unmapped", 8'h01, {7'h00, err});
        // t=0 timer0 div12, t=1 timer1 div4, both gated
        for (t = 0; t < 2; t++) begin
            pins.hold(int'(t), 1'b0);
            wr(tdc_pkg::TDC_IDX_TMODE, 8'(9 << 4 * t));
            wr(tdc_pkg::TDC_IDX_CLKSEL, 8'(t << 4));
            wr(tdc_pkg::TDC_IDX_LOW0 + t, 8'h00);
            wr(tdc_pkg::TDC_IDX_TCTRL, 8'(16 << 2 * t));
            repeat (40) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("gated", 8'h00, v);
            pins.hold(int'(t), 1'b1);
            wr(tdc_pkg::TDC_IDX_LOW0 + t, 8'h00);
            repeat (117) @(posedge clk);
            wr(tdc_pkg::TDC_IDX_TCTRL, 8'h00);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chkr("ticks", ticks(120, t) - 8'd1, ticks(120, t) + 8'd1, v);
            m = v;
            repeat (30) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("halt", m, v);
            k = 1 + ($random(seed) & 15);
            wr(tdc_pkg::TDC_IDX_TMODE, 8'(5 << 4 * t));
            wr(tdc_pkg::TDC_IDX_LOW0 + t, 8'h00);
            wr(tdc_pkg::TDC_IDX_TCTRL, 8'(16 << 2 * t));
            repeat (k) pins.pulse(2 + int'(t), 1 + ($random(seed) & 3));
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("edges", 8'(k), v);
            // enable low: a pin pulse must leave no trace
            ce <= 1'b0;
            pins.pulse(2 + int'(t), 2);
            ce <= 1'b1;
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("frozen", 8'(k), v);
            wr(tdc_pkg::TDC_IDX_TMODE, 8'(4 << 4 * t));
            wr(tdc_pkg::TDC_IDX_LOW0 + t, 8'hFF);
            pins.pulse(2 + int'(t), 2);
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("prescale low", 8'hE0, v);
            rd(tdc_pkg::TDC_IDX_HIGH0 + t);
            chk("prescale high", 8'h01, v);
            wr(tdc_pkg::TDC_IDX_TMODE, 8'(6 << 4 * t));
            wr(tdc_pkg::TDC_IDX_HIGH0 + t, 8'hA5);
            wr(tdc_pkg::TDC_IDX_LOW0 + t, 8'hFF);
            pins.pulse(2 + int'(t), 2);
            repeat (6) @(posedge clk);
            chk("masked irq", 8'h00, {7'h00, irq});
            rd(tdc_pkg::TDC_IDX_LOW0 + t);
            chk("reload", 8'hA5, v);
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("ovf flag", 8'(48 << 2 * t), v);
            wr(tdc_pkg::TDC_IDX_IRQ_MASK, 8'(1 << t));
            repeat (2) @(posedge clk);
            chk("irq", 8'h01, {7'h00, irq});
            wr(tdc_pkg::TDC_IDX_ISR_ENTRY, 8'(1 << t));
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("entry clear", 8'(16 << 2 * t), v);
            wr(tdc_pkg::TDC_IDX_IRQ_STATUS, 8'(1 << t));
            repeat (2) @(posedge clk);
            chk("irq clear", 8'h00, {7'h00, irq});
        end
        // split mode: high half of timer0 on timer1 run bit, timer1 holds
        wr(tdc_pkg::TDC_IDX_TMODE, 8'h33);
        wr(tdc_pkg::TDC_IDX_CLKSEL, 8'h00);
        wr(tdc_pkg::TDC_IDX_HIGH0, 8'h00);
        rd(tdc_pkg::TDC_IDX_LOW1);
        m = v;
        wr(tdc_pkg::TDC_IDX_TCTRL, 8'h40);
        repeat (117) @(posedge clk);
        wr(tdc_pkg::TDC_IDX_TCTRL, 8'h00);
        rd(tdc_pkg::TDC_IDX_HIGH0);
        chkr("split high", ticks(120, 0) - 8'd1, ticks(120, 0) + 8'd1, v);
        rd(tdc_pkg::TDC_IDX_LOW1);
        chk("t1 stopped", m, v);
        for (t = 0; t < 2; t++) begin
            wr(tdc_pkg::TDC_IDX_TCTRL, 8'(1 << 2 * t));
            wr(tdc_pkg::TDC_IDX_IRQ_MASK, 8'(4 << t));
            pins.pulse(int'(t), 2);
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("edge flag", 8'(3 << 2 * t), v);
            chk("ext irq", 8'h01, {7'h00, irq});
            wr(tdc_pkg::TDC_IDX_ISR_ENTRY, 8'(4 << t));
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("edge clear", 8'(1 << 2 * t), v);
            wr(tdc_pkg::TDC_IDX_IRQ_STATUS, 8'(4 << t));
            wr(tdc_pkg::TDC_IDX_TCTRL, 8'h00);
            pins.hold(int'(t), 1'b0);
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("level low", 8'(2 << 2 * t), v);
            pins.hold(int'(t), 1'b1);
            repeat (6) @(posedge clk);
            rd(tdc_pkg::TDC_IDX_TCTRL);
            chk("level high", 8'h00, v);
        end
        test_done();
    end
endmodule
bind tdc_timer_ctrl tdc_monitor mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq0_pin(ext_irq0_pin), .irq(irq));
